// ---- prtp_checker.sv ----
`default_nettype none
// Function
// - Address space seen as 4 KB pages
// - Two-bit rights decode to three levels
// - Rights meaning depends on privilege
// - Unauthorized pointer creation clears the tag
// - Objects 64 bytes up; accesses bounded
// - Objects selected by tagged 33-bit pointer
// - Faults only in virtual mode; forge check in both
// - Four 1 GB regions; top region shared
module prtp_checker
    import prtp_pkg::*;
#(
    parameter int unsigned OBJ_ENTRIES = 16
) (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    // Core access request
    input  wire logic                        reqValid,
    input  wire prtp_pkg::prtp_kind_t        reqKind,
    input  wire logic [prtp_pkg::ADDR_W-1:0] reqAddr,
    input  wire logic                        reqSupervisor,
    input  wire logic                        reqUseObject,
    input  wire logic [prtp_pkg::DATA_W:0]   reqPointer,
    // Page table entry for the request
    input  wire logic [prtp_pkg::RIGHTS_W-1:0] pteRights,
    input  wire logic [19:0]                 pteFrame,
    // Core tagged store path
    input  wire logic [prtp_pkg::DATA_W-1:0] storeData,
    input  wire logic                        storeTagReq,
    input  wire logic                        storeAuthorized,
    // Object table loading
    input  wire logic                        objWrite,
    input  wire logic [$clog2(OBJ_ENTRIES)-1:0] objIndex,
    input  wire logic [prtp_pkg::ADDR_W-1:0] objBase,
    input  wire logic [prtp_pkg::ADDR_W-1:0] objSize,
    // Register port
    input  wire logic [7:0]                  regAddr,
    input  wire logic [31:0]                 regWdata,
    input  wire logic                        regWrite,
    input  wire logic                        regRead,
    output logic [31:0]                      regRdata,
    // Bus side
    output logic                             busValid,
    output logic [prtp_pkg::ADDR_W-1:0]      busAddr,
    output logic                             busWrite,
    output logic [prtp_pkg::DATA_W:0]        busWdata,
    // Core answer
    output logic                             protFault,
    output logic                             irq
);
    import prtp_pkg::*;

    // Object descriptor table
    logic [ADDR_W-1:0] objBaseMem [OBJ_ENTRIES];
    logic [ADDR_W-1:0] objSizeMem [OBJ_ENTRIES];

    // Software registers
    logic [31:0]     ctrl_q;       // Mode control
    logic [EV_W-1:0] status_q;     // Sticky events
    logic [EV_W-1:0] enable_q;     // Interrupt enables
    logic [ADDR_W-1:0] faultAddr_q; // Last faulting address
    logic [7:0]      faultInfo_q;  // Last fault kind and privilege
    logic [ADDR_W-1:0] regionBase_q [4]; // Per-region table base
    logic [1:0]      regionDepth_q [4];  // Table levels per region
    logic [31:0]     rdata_q;      // Read data stage

    // Output stage
    logic                busValid_q;
    logic [ADDR_W-1:0]   busAddr_q;
    logic                busWrite_q;
    logic [DATA_W:0]     busWdata_q;
    logic                fault_q;

    // Mode and privilege
    wire virtMode = ctrl_q[CTRL_VIRT_BIT];
    // Only stores need write rights
    wire isWrite  = (reqKind == PRTP_STORE);

    // Raises a stored size to the smallest legal object of 64 bytes
    function automatic logic [ADDR_W-1:0] prtp_min_size(input logic [ADDR_W-1:0] s);
        prtp_min_size = (s < ADDR_W'(OBJ_MIN_BYTES)) ? ADDR_W'(OBJ_MIN_BYTES) : s;
    endfunction : prtp_min_size

    prtp_perm_t perm;
    prtp_rights_decode u_decode (
        .rights     (pteRights),
        .supervisor (reqSupervisor),
        .perm       (perm)
    );

    // pointer selection
    // Tag is the top bit of the 33-bit pointer word
    wire ptrTagOk = reqPointer[DATA_W];
    // Index sits just above the 64-byte granule offset
    wire [$clog2(OBJ_ENTRIES)-1:0] objSel = reqPointer[$clog2(OBJ_ENTRIES)+5:6];
    wire [ADDR_W-1:0] selBase = objBaseMem[objSel];
    wire [ADDR_W-1:0] rawSize = objSizeMem[objSel];       // Size as software stored it
    wire [ADDR_W-1:0] selSize = prtp_min_size(rawSize);    // Size with the 64-byte floor

    // object offset bounding
    // A stored size of zero stands for the full 32-bit range and never bounds
    wire boundBad = reqUseObject && (rawSize != '0) && (reqAddr >= selSize);
    wire [ADDR_W-1:0] linAddr = reqUseObject ? (selBase + reqAddr) : reqAddr;

    wire [1:0] region     = linAddr[ADDR_W-1:REGION_SHIFT];
    wire       regionFlat = (regionDepth_q[region] == 2'd0);

    // page-granular translation
    // Flat regions pass the linear address, paged ones take the frame
    wire [ADDR_W-1:0] physAddr = regionFlat ? linAddr
                               : {pteFrame, linAddr[PAGE_SHIFT-1:0]};

    // permission per access kind
    // Loads and fetches need any read right, stores read-write
    wire rightsBad = (perm == PRTP_NO_ACCESS) || (isWrite && perm != PRTP_READ_WRITE);

    wire tagBad   = reqUseObject && !ptrTagOk;
    // Physical mode never faults
    wire anyFault = reqValid && virtMode && (rightsBad || tagBad || boundBad);

    // forged pointer attempt
    // Counted in either mode; the store still goes out untagged
    wire forge    = reqValid && isWrite && storeTagReq && !storeAuthorized;
    wire tagOut   = storeTagReq && storeAuthorized;

    // Event vector
    // One bit per event kind, in status bit order
    wire [EV_W-1:0] events = {forge,
                              anyFault && boundBad,
                              anyFault && tagBad,
                              anyFault && rightsBad};

    // Register decode
    wire wrCtrl   = regWrite && regAddr == OFS_CTRL;
    wire wrClear  = regWrite && regAddr == OFS_CLEAR;
    wire wrEnable = regWrite && regAddr == OFS_ENABLE;
    wire wrRegion = regWrite && regAddr[7:4] == OFS_RBASE0[7:4];
    wire wrDepth  = regWrite && regAddr[7:4] == OFS_RDEPTH[7:4];
    // Word slot within a region bank
    wire [1:0] regSlot = regAddr[3:2];

    // Read mux, unmapped reads return zero
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        case (regAddr)
            OFS_CTRL:   rdMux = ctrl_q;
            OFS_STATUS: rdMux = {28'h0000000, status_q};
            OFS_ENABLE: rdMux = {28'h0000000, enable_q};
            OFS_FADDR:  rdMux = faultAddr_q;
            OFS_FINFO:  rdMux = {24'h000000, faultInfo_q};
            default: begin
                // Region banks decode on the upper nibble
                if (regAddr[7:4] == OFS_RBASE0[7:4]) begin
                    rdMux = regionBase_q[regSlot];
                end else if (regAddr[7:4] == OFS_RDEPTH[7:4]) begin
                    rdMux = {30'h00000000, regionDepth_q[regSlot]};
                end
            end
        endcase
    end

    // Region depth written as three saturates at two levels,
    // so a bad code cannot select a missing walk level
    wire [1:0] depthIn = (regWdata[1:0] == 2'd3) ? 2'd2 : regWdata[1:0];

    // Status bits that a write to the clear register drops
    wire [EV_W-1:0] clrMask = wrClear ? regWdata[EV_W-1:0] : EV_RESET;

    // only a clean request reaches the bus
    wire accept = reqValid && !anyFault;

    // physical mode passes the address unchanged
    wire [ADDR_W-1:0] fwdAddr = virtMode ? physAddr : reqAddr;

    wire [DATA_W:0] fwdData = {tagOut, storeData};

    // Mode control and interrupt enables
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Start in physical mode with all interrupts masked
            ctrl_q   <= CTRL_RESET;
            enable_q <= EV_RESET;
        end else begin
            // Software writes take effect from the next cycle
            if (wrCtrl) begin
                ctrl_q <= regWdata;
            end
            if (wrEnable) begin
                enable_q <= regWdata[EV_W-1:0];
            end
        end
    end

    // region table bases and depths
    // One set of region registers serves every process, so the top
    // region is shared by construction
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // All regions flat until software sets up tables
            for (int i = 0; i < 4; i++) begin
                regionBase_q[i]  <= 32'h0000_0000;
                regionDepth_q[i] <= 2'h0;
            end
        end else begin
            if (wrRegion) begin
                regionBase_q[regSlot] <= regWdata;
            end
            if (wrDepth) begin
                regionDepth_q[regSlot] <= depthIn;
            end
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= EV_RESET;
        end else begin
            // An event in the cycle of a clear keeps its bit
            status_q <= (status_q & ~clrMask) | events;
        end
    end

    // Fault capture
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            faultAddr_q <= 32'h0000_0000;
            faultInfo_q <= 8'h00;
        end else if (anyFault) begin
            // Latest fault overwrites the record
            faultAddr_q <= reqAddr;
            // Privilege, kind and rights packed in one byte
            faultInfo_q <= {3'h0, reqSupervisor, 2'(reqKind), pteRights};
        end
    end

    // Object table loading
    // No reset: software fills entries before any object access
    always_ff @(posedge sys_clk) begin
        // Base and size of one entry change together
        if (objWrite) begin
            objBaseMem[objIndex] <= objBase;
            objSizeMem[objIndex] <= objSize;
        end
    end

    // answer strobes, exactly one per request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busValid_q <= 1'b0;
            fault_q    <= 1'b0;
        end else begin
            // A fault blocks the forward strobe in the same cycle
            busValid_q <= accept;
            fault_q    <= anyFault;
        end
    end

    // Read data stands for one cycle only, zero otherwise
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= regRead ? rdMux : 32'h0000_0000;
        end
    end

    // Forwarded access, held until the next accepted request
    // Loads carry the store word too; memory ignores it on reads
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busAddr_q  <= 32'h0000_0000;
            busWrite_q <= 1'b0;
            busWdata_q <= '0;
        end else if (accept) begin
            // Blocked requests leave the last forwarded word in place
            busAddr_q  <= fwdAddr;
            busWrite_q <= isWrite;
            busWdata_q <= fwdData;
        end
    end

    // Outputs straight from the stage registers
    assign busValid  = busValid_q;
    assign busAddr   = busAddr_q;
    assign busWrite  = busWrite_q;
    assign busWdata  = busWdata_q;
    assign protFault = fault_q;
    assign regRdata  = rdata_q;
    // Interrupt level follows the enabled sticky bits
    assign irq       = |(status_q & enable_q);
endmodule : prtp_checker
`default_nettype wire

// ---- prtp_checker_monitor.sv ----
`default_nettype none
module prtp_checker_monitor
    import prtp_pkg::*;
(
    // Clock and reset
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    // Core request
    input wire logic                 reqValid,
    input wire prtp_pkg::prtp_kind_t reqKind,
    input wire logic [31:0]          reqAddr,
    input wire logic                 reqSupervisor,
    input wire logic                 reqUseObject,
    input wire logic [32:0]          reqPointer,
    input wire logic [1:0]           pteRights,
    input wire logic                 storeTagReq,
    input wire logic                 storeAuthorized,
    input wire logic [31:0]          storeData,
    // Register port
    input wire logic [7:0]           regAddr,
    input wire logic [31:0]          regWdata,
    input wire logic                 regWrite,
    input wire logic                 regRead,
    input wire logic [31:0]          regRdata,
    // Bus side and answers
    input wire logic                 busValid,
    input wire logic [31:0]          busAddr,
    input wire logic                 busWrite,
    input wire logic [32:0]          busWdata,
    input wire logic                 protFault
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic virtQ;  // Shadow of the virtual-mode control bit
    // Follows software writes to the control register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) virtQ <= 1'b0;
        else if (regWrite && regAddr == OFS_CTRL) virtQ <= regWdata[CTRL_VIRT_BIT];
    end
    property p_one_ans; reqValid |=> busValid ^ protFault; endproperty
    a_one_ans: assert property (p_one_ans) else $error("request without one answer");
    property p_quiet; !reqValid |=> !busValid && !protFault; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_fwd; reqValid |=> !busValid || (busWrite == ($past(reqKind) == PRTP_STORE)
        && busWdata[31:0] == $past(storeData)); endproperty
    a_fwd: assert property (p_fwd) else $error("forwarded word differs from request");
    property p_phys; reqValid && !virtQ |=> busValid && busAddr == $past(reqAddr); endproperty
    a_phys: assert property (p_phys) else $error("physical address altered");
    property p_tag;
        reqValid && !virtQ && reqKind == PRTP_STORE
        |=> busWdata[32] == ($past(storeTagReq) && $past(storeAuthorized));
    endproperty
    a_tag: assert property (p_tag) else $error("stored tag wrong");
    property p_user_none; reqValid && virtQ && !reqSupervisor && !pteRights[1]
        |=> protFault && !busValid; endproperty
    a_user_none: assert property (p_user_none) else $error("user access not blocked");
    property p_sup_ro; reqValid && virtQ && reqSupervisor && pteRights == 2'b00
        && reqKind == PRTP_STORE |=> protFault; endproperty
    a_sup_ro: assert property (p_sup_ro) else $error("store to read-only page");
    property p_bad_ptr; reqValid && virtQ && reqUseObject && !reqPointer[32] |=> protFault;
    endproperty
    a_bad_ptr: assert property (p_bad_ptr) else $error("untagged pointer used");
    property p_rdata; !regRead |=> regRdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside read slot");
    c_fault: cover property (reqValid && virtQ ##1 protFault);
    c_tagged: cover property (busValid && busWdata[32]);
    c_obj: cover property (reqValid && reqUseObject ##1 busValid);
endmodule : prtp_checker_monitor
bind prtp_checker prtp_checker_monitor u_mon (.*);
`default_nettype wire

// ---- prtp_core_model.sv ----
`default_nettype none
module prtp_core_model
    import prtp_pkg::*;
#(
    parameter logic [19:0] FRAME = 20'h5a5a3
) (
    // Clock
    input  wire logic            sys_clk,
    // Access request
    output prtp_pkg::prtp_kind_t reqKind,
    output logic                 reqValid,
    output logic [31:0]          reqAddr,
    output logic                 reqSupervisor,
    output logic                 reqUseObject,
    output logic [32:0]          reqPointer,
    // Page entry and tagged store
    output logic [1:0]           pteRights,
    output logic [19:0]          pteFrame,
    output logic [31:0]          storeData,
    output logic                 storeTagReq,
    output logic                 storeAuthorized
);
    // Drives one full set of request signals
    task automatic put(input logic v, input prtp_kind_t k, input logic [31:0] a,
        input logic s, input logic [1:0] r, input logic u, input logic [32:0] p,
        input logic t, input logic au);
        reqValid <= v; reqKind <= k; reqAddr <= a; reqSupervisor <= s;
        pteRights <= r; reqUseObject <= u; reqPointer <= p; storeTagReq <= t;
        storeAuthorized <= au; pteFrame <= FRAME; storeData <= $urandom;
    endtask : put
    initial put(1'b0, PRTP_LOAD, 32'h0, 1'b0, 2'h0, 1'b0, 33'h0, 1'b0, 1'b0);
    // One request cycle; stays valid so calls may run back to back
    task automatic access(input prtp_kind_t k, input logic [31:0] a, input logic s,
        input logic [1:0] r, input logic u, input logic [32:0] p, input logic t, au);
        @(posedge sys_clk);
        put(1'b1, k, a, s, r, u, p, t, au);
    endtask : access
    // Release: address lines show garbage, not the last value
    task automatic idle();
        @(posedge sys_clk);
        put(1'b0, PRTP_LOAD, ~reqAddr, 1'b0, 2'h0, 1'b0, ~reqPointer, 1'b0, 1'b0);
    endtask : idle
endmodule : prtp_core_model
`default_nettype wire

// ---- prtp_pkg.sv ----
`default_nettype none
package prtp_pkg;
    // Address geometry
    localparam int unsigned PAGE_BYTES     = 4096;
    localparam int unsigned PAGE_SHIFT     = 12;
    localparam int unsigned ADDR_W         = 32;
    localparam int unsigned DATA_W         = 32;
    localparam int unsigned REGION_SHIFT   = 30;
    localparam int unsigned OBJ_MIN_BYTES  = 64;
    localparam int unsigned OBJ_INDEX_W    = 26;
    localparam int unsigned VIRT_W         = 58;
    localparam int unsigned RIGHTS_W       = 2;

    // Register offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_CLEAR   = 8'h08;
    localparam logic [7:0] OFS_ENABLE  = 8'h0c;
    localparam logic [7:0] OFS_FADDR   = 8'h10;
    localparam logic [7:0] OFS_FINFO   = 8'h14;
    localparam logic [7:0] OFS_RBASE0  = 8'h20;
    localparam logic [7:0] OFS_RDEPTH  = 8'h30;

    // Control register fields
    localparam int unsigned CTRL_VIRT_BIT = 0;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // Status and enable fields
    localparam int unsigned EV_RIGHTS_BIT = 0;
    localparam int unsigned EV_TAG_BIT    = 1;
    localparam int unsigned EV_BOUND_BIT  = 2;
    localparam int unsigned EV_FORGE_BIT  = 3;
    localparam int unsigned EV_W          = 4;
    localparam logic [EV_W-1:0] EV_RESET  = 4'h0;

    // Decoded permission levels
    typedef enum logic [1:0] {
        PRTP_NO_ACCESS,
        PRTP_READ_ONLY,
        PRTP_READ_WRITE
    } prtp_perm_t;

    // Access kinds
    typedef enum logic [1:0] {
        PRTP_LOAD,
        PRTP_STORE,
        PRTP_FETCH
    } prtp_kind_t;
endpackage : prtp_pkg
`default_nettype wire

// ---- prtp_rights_decode.sv ----
`default_nettype none
// Turns page rights and privilege into a permission level
module prtp_rights_decode
    import prtp_pkg::*;
(
    // Inputs
    input  wire logic [prtp_pkg::RIGHTS_W-1:0] rights,
    input  wire logic                          supervisor,
    // Result
    output prtp_pkg::prtp_perm_t               perm
);
    // Supervisor reads every code and writes every code but 00
    assign perm = supervisor ? ((rights == 2'b00) ? PRTP_READ_ONLY : PRTP_READ_WRITE)
                : (rights == 2'b11) ? PRTP_READ_WRITE
                : (rights == 2'b10) ? PRTP_READ_ONLY
                : PRTP_NO_ACCESS;
endmodule : prtp_rights_decode
`default_nettype wire

// ---- tb_prtp_checker.sv ----
`default_nettype none
module tb_prtp_checker
    import prtp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] FR = 20'h5a5a3;  // Frame number the core model returns
    logic sys_clk = 1'b0, rst_n = 1'b0, rdPend = 1'b0;
    logic [7:0] regAddr; logic [31:0] regWdata, regRdata, busAddr, objBase, objSize, a, b;
    logic regWrite, regRead, objWrite, busValid, busWrite, protFault, irq, s;
    logic [3:0] objIndex; logic [32:0] busWdata, reqPointer; logic [1:0] r, pteRights;
    logic reqValid, reqSupervisor, reqUseObject, storeTagReq, storeAuthorized;
    logic [31:0] reqAddr, storeData; logic [19:0] pteFrame; prtp_kind_t reqKind, k;
    logic [33:0] aq[$], rq[$];  // Expected access results and read data
    int errCount = 0, comparisons = 0, i;
    always #10 sys_clk = ~sys_clk;
    prtp_checker DUT (.*);
    prtp_core_model #(.FRAME(FR)) core (.*);
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errCount++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("comparisons=%0d mismatches=%0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge sys_clk); regAddr <= ad; regWdata <= d; regWrite <= 1'b1;
        @(posedge sys_clk); regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        rq.push_back({2'b00, e});
        @(posedge sys_clk); regAddr <= ad; regRead <= 1'b1;
        @(posedge sys_clk); regRead <= 1'b0;
    endtask : rd
    // Waits, bounded, until every noted result has been seen
    task automatic drain(input string n);
        int w; w = 0;
        while (aq.size() + rq.size() != 0 && w < 20) begin @(posedge sys_clk); w++; end
        if (aq.size() + rq.size() != 0) begin
            errCount++;
            $display("[ERR] t=%0t no answer, %0h notes left", $time, aq.size() + rq.size());
            test_done();
        end
        $display("test %s done", n);
    endtask : drain
    // Expected answer from privilege, rights and access kind
    function automatic logic [33:0] expAcc(prtp_kind_t kk, logic [31:0] ad, logic ss,
        logic [1:0] rr);
        logic rw; rw = ss ? (rr != 2'b00) : (rr == 2'b11);
        return (!(ss | rr[1]) || (kk == PRTP_STORE && !rw)) ? {1'b1, 33'h0} : {1'b0, ad, 1'b0};
    endfunction : expAcc
    // Watches answers and compares with the oldest note
    always @(posedge sys_clk) begin
        rdPend <= regRead;
        if (rdPend) chk({2'b00, regRdata}, rq.size() ? rq.pop_front() : 34'bx);
        if (busValid || protFault)
            chk({protFault, busValid ? busAddr : 32'h0, busValid & busWdata[32]},
                aq.size() ? aq.pop_front() : 34'bx);
    end
    initial begin
        void'($urandom(32'h0e02));
        regAddr <= 8'h0; regWdata <= 32'h0; regWrite <= 1'b0; regRead <= 1'b0;
        objWrite <= 1'b0; objIndex <= 4'h0; objBase <= 32'h0; objSize <= 32'h0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL, 32'h0); rd(OFS_STATUS, 32'h0); rd(OFS_ENABLE, 32'h0); rd(8'hfc, 32'h0);
        drain("reset");
        a = $urandom; aq.push_back({1'b0, a, 1'b0});
        core.access(PRTP_STORE, a, 1'b0, 2'h0, 1'b1, 33'h0, 1'b1, 1'b0);
        a = $urandom; aq.push_back({1'b0, a, 1'b1});
        core.access(PRTP_STORE, a, 1'b0, 2'h0, 1'b0, 33'h0, 1'b1, 1'b1);
        core.idle(); drain("physical");
        wr(OFS_CTRL, 32'h1);
        for (i = 0; i < 4; i++) wr(OFS_RDEPTH + 8'(4 * i), 32'h0);
        for (i = 0; i < 24; i++) begin
            k = prtp_kind_t'(i % 3); s = 1'(i / 12); r = 2'((i / 3) % 4); a = $urandom;
            aq.push_back(expAcc(k, a, s, r));
            core.access(k, a, s, r, 1'b0, 33'h0, 1'b0, 1'b0);
        end
        core.idle(); drain("rights");
        b = $urandom;
        @(posedge sys_clk); objWrite <= 1'b1; objIndex <= 4'h3; objBase <= b; objSize <= 32'h40;
        @(posedge sys_clk); objWrite <= 1'b0;
        aq.push_back({1'b0, b + 32'h3f, 1'b0});
        core.access(PRTP_LOAD, 32'h3f, 1'b0, 2'h3, 1'b1, 33'h1_0000_00c0, 1'b0, 1'b0);
        aq.push_back({1'b1, 33'h0});
        core.access(PRTP_LOAD, 32'h40, 1'b0, 2'h3, 1'b1, 33'h1_0000_00c0, 1'b0, 1'b0);
        aq.push_back({1'b1, 33'h0});
        core.access(PRTP_FETCH, 32'h0, 1'b0, 2'h3, 1'b1, 33'h0_0000_00c0, 1'b0, 1'b0);
        core.idle(); drain("object");
        wr(OFS_RDEPTH + 8'h04, 32'h1); a = {2'b01, 30'($urandom)};
        aq.push_back({1'b0, FR, a[11:0], 1'b0});
        core.access(PRTP_LOAD, a, 1'b1, 2'h0, 1'b0, 33'h0, 1'b0, 1'b0);
        core.idle(); drain("paging");
        rd(OFS_STATUS, 32'hf); drain("status");
        chk({33'h0, irq}, 34'h0);
        wr(OFS_ENABLE, 32'h1); #1 chk({33'h0, irq}, 34'h1);
        wr(OFS_CLEAR, 32'h1); #1 chk({33'h0, irq}, 34'h0);
        rd(OFS_STATUS, 32'he); drain("irq");
        test_done();
    end
endmodule : tb_prtp_checker
`default_nettype wire
